// >>> hw/hsc_cycle_timer.sv
// loadable down counter with a one-cycle done pulse
`timescale 1ns/10ps
module hsc_cycle_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  // status
  output logic busy,
  output logic done
);
  import hsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } hsc_tmr_s;

  hsc_tmr_s s;
  hsc_tmr_s next_s;

  // count down, pulse done as the count leaves one
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (load)
    begin
      next_s.cnt = load_value;
    end
    else if (s.cnt != '0)
    begin
      next_s.cnt = s.cnt - 1'b1;
      next_s.done = (s.cnt == W'(1));
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign busy = (s.cnt != '0);
  assign done = s.done;

endmodule : hsc_cycle_timer

// >>> hw/hsc_seg_search.sv
// binary search over the oscillator tuning segments
`timescale 1ns/10ps
module hsc_seg_search #(
  parameter int unsigned SETTLE = hsc_pkg::SEARCH_SETTLE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic cv_high,
  // result
  output logic busy,
  output logic done,
  output logic [3:0] segment
);
  import hsc_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [1:0] bit_idx;
    logic [7:0] wait_cnt;
    logic [3:0] seg;
  } hsc_srch_s;

  hsc_srch_s s;
  hsc_srch_s next_s;

  // try each bit from the top; keep it while the control voltage sits high
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (start)
    begin
      next_s.busy = 1'b1;
      next_s.bit_idx = 2'h3;
      next_s.seg = 4'h8;
      next_s.wait_cnt = 8'(SETTLE);
    end
    else if (s.busy)
    begin
      if (s.wait_cnt != 8'h00)
        next_s.wait_cnt = s.wait_cnt - 8'h01;
      else
      begin
        if (!cv_high)
          next_s.seg[s.bit_idx] = 1'b0;
        if (s.bit_idx == 2'h0)
        begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
        else
        begin
          next_s.bit_idx = s.bit_idx - 2'h1;
          next_s.seg[s.bit_idx - 2'h1] = 1'b1;
          next_s.wait_cnt = 8'(SETTLE);
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign busy = s.busy;
  assign done = s.done;
  assign segment = s.seg;

endmodule : hsc_seg_search

// >>> hw/hsc_synth_rf_ctrl.sv
// synthesizer control and rf field state for the reader core
`timescale 1ns/10ps
module hsc_synth_rf_ctrl #(
  parameter int unsigned RAMP_100_CYC = hsc_pkg::RAMP_100_CYC,
  parameter int unsigned RAMP_200_CYC = hsc_pkg::RAMP_200_CYC,
  parameter int unsigned RAMP_400_CYC = hsc_pkg::RAMP_400_CYC,
  parameter int unsigned XOSC_FAST_CYC = hsc_pkg::XOSC_FAST_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // direct commands
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  // interrupt
  output logic irq,
  input wire logic irq_ack,
  // analog feedback
  input wire logic vco_cv_high,
  input wire logic [2:0] vco_cv_level,
  // synthesizer controls
  output logic test_out_fast_drive,
  output logic [3:0] vco_segment,
  output logic vco_cv_measure,
  output logic [9:0] div_a,
  output logic [9:0] div_b,
  output logic [16:0] div_ratio,
  output logic [2:0] comparison_freq_select,
  output logic [9:0] ref_divide,
  output logic [2:0] pump_current_select,
  output logic [1:0] loop_resistor_select,
  output logic [2:0] loop_capacitor_select,
  output logic xosc_fast_mode,
  // rf state
  output logic tx_enable,
  output logic rx_enable,
  output logic agc_enable,
  output logic standby,
  output logic rf_ramping,
  output logic rf_ready,
  // protocol options
  output logic protocol_gen2,
  output logic protocol_fm0,
  output logic auto_ack_en,
  output logic auto_handle_en,
  output logic rx_crc_check_en,
  output logic direct_mode
);
  import hsc_pkg::*;

  typedef struct packed {
    logic [7:0] dsc;
    logic [7:0] prot;
    logic [7:0] txo;
    logic [7:0] misc1;
    logic [7:0] misc2;
    logic [7:0] osc;
    logic [7:0] pump;
    logic [7:0] mod3;
    logic [7:0] page;
    logic [23:0] main_set;
    logic [23:0] aux_set;
    logic use_auto;
    logic aux_active;
    logic rf_ready;
    logic search_done;
    logic irq_cmd;
    logic irq_ana;
    hsc_rf_e rf_state;
    logic [16:0] div_ratio;
    logic [7:0] rd_data;
    logic xosc_started;
    logic xosc_done;
  } hsc_top_s;

  hsc_top_s s;
  hsc_top_s next_s;
  logic ramp_load;
  logic ramp_done;
  logic [RAMP_W-1:0] ramp_len;
  logic xosc_load;
  logic xosc_done;
  logic search_start;
  logic search_busy;
  logic search_done;
  logic [3:0] search_seg;
  logic [23:0] act_set;
  logic [16:0] ratio_calc;
  logic rf_en;
  logic cmd_auto;
  logic cmd_manual;

  // command decode
  assign cmd_auto = cmd_valid && (cmd_code == CMD_AUTO_RANGE);
  assign cmd_manual = cmd_valid && (cmd_code == CMD_MANUAL_RANGE);
  assign search_start = cmd_auto;
  assign rf_en = s.dsc[DSC_RF_ENABLE];

  // active divider set and its total ratio
  assign act_set = s.aux_active ? s.aux_set : s.main_set;
  assign ratio_calc = 17'(act_set[SET_B_LSB +: 10] * PRESCALE_LOW)
    + 17'(act_set[SET_A_LSB +: 10] * PRESCALE_HIGH);

  // ramp length from the ramp field, last code scales with tari
  always_comb
  begin
    case (s.mod3[MOD3_RAMP_LSB +: 2])
      2'h0: ramp_len = RAMP_W'(RAMP_100_CYC);
      2'h1: ramp_len = RAMP_W'(RAMP_200_CYC);
      2'h2: ramp_len = RAMP_W'(RAMP_400_CYC);
      default: ramp_len = RAMP_W'((TARI_RAMP_MULT * TARI_BASE_CYC) << s.txo[1:0]);
    endcase
  end

  // register writes, commands, rf sequencing and read data
  always_comb
  begin
    next_s = s;
    ramp_load = 1'b0;
    xosc_load = 1'b0;
    if (reg_wr_en)
    begin
      case (reg_addr)
        ADDR_DEV_STATUS: next_s.dsc = reg_wr_data;
        ADDR_PROTOCOL: next_s.prot = reg_wr_data;
        ADDR_TX_OPTIONS: next_s.txo = reg_wr_data;
        ADDR_MISC_ONE: next_s.misc1 = reg_wr_data;
        ADDR_MISC_TWO: next_s.misc2 = reg_wr_data;
        ADDR_OSC_CTRL: next_s.osc = reg_wr_data;
        ADDR_PUMP_CTRL: next_s.pump = reg_wr_data;
        ADDR_MOD_THREE: next_s.mod3 = reg_wr_data;
        ADDR_MAIN_ONE: next_s.main_set[23:16] = reg_wr_data;
        ADDR_MAIN_TWO: next_s.main_set[15:8] = reg_wr_data;
        ADDR_MAIN_THREE: next_s.main_set[7:0] = reg_wr_data;
        ADDR_AUX_ONE: next_s.aux_set[23:16] = reg_wr_data;
        ADDR_AUX_TWO: next_s.aux_set[15:8] = reg_wr_data;
        ADDR_AUX_THREE: next_s.aux_set[7:0] = reg_wr_data;
        ADDR_PAGE_SEL: next_s.page = reg_wr_data;
        default: next_s.page = s.page;
      endcase
    end
    // direct commands
    if (cmd_valid)
    begin
      case (cmd_code)
        CMD_HOP_MAIN: next_s.aux_active = 1'b0;
        CMD_HOP_AUX: next_s.aux_active = 1'b1;
        CMD_AUTO_RANGE: next_s.use_auto = 1'b1;
        CMD_MANUAL_RANGE: next_s.use_auto = 1'b0;
        default: next_s.use_auto = s.use_auto;
      endcase
    end
    next_s.div_ratio = ratio_calc;
    // flags clear on acknowledge, a new event wins
    if (irq_ack)
    begin
      next_s.irq_cmd = 1'b0;
      next_s.irq_ana = 1'b0;
      next_s.search_done = 1'b0;
    end
    if (cmd_auto)
      next_s.search_done = 1'b0;
    if (search_done)
    begin
      next_s.search_done = 1'b1;
      next_s.irq_cmd = 1'b1;
    end
    // rf field ramp sequence
    case (s.rf_state)
      RF_OFF:
        if (rf_en)
        begin
          next_s.rf_state = RF_UP;
          ramp_load = 1'b1;
        end
      RF_UP:
        if (!rf_en)
        begin
          next_s.rf_state = RF_DOWN;
          ramp_load = 1'b1;
        end
        else if (ramp_done)
        begin
          next_s.rf_state = RF_ENABLE;
          next_s.rf_ready = 1'b1;
          next_s.irq_ana = 1'b1;
        end
      RF_ENABLE:
        if (!rf_en)
        begin
          next_s.rf_state = RF_DOWN;
          next_s.rf_ready = 1'b0;
          ramp_load = 1'b1;
        end
      RF_DOWN:
        if (ramp_done)
        begin
          next_s.rf_state = RF_OFF;
          next_s.irq_ana = 1'b1;
        end
      default: next_s.rf_state = RF_OFF;
    endcase
    // crystal fast window starts once after reset
    if (!s.xosc_started)
    begin
      next_s.xosc_started = 1'b1;
      xosc_load = 1'b1;
    end
    if (xosc_done)
      next_s.xosc_done = 1'b1;
    // registered read data
    if (reg_rd_en)
    begin
      case (reg_addr)
        ADDR_DEV_STATUS: next_s.rd_data = s.dsc;
        ADDR_PROTOCOL: next_s.rd_data = s.prot;
        ADDR_TX_OPTIONS: next_s.rd_data = s.txo;
        ADDR_MISC_ONE: next_s.rd_data = s.misc1;
        ADDR_MISC_TWO: next_s.rd_data = s.misc2;
        ADDR_OSC_CTRL: next_s.rd_data = s.osc;
        ADDR_PUMP_CTRL: next_s.rd_data = s.pump;
        ADDR_MOD_THREE: next_s.rd_data = s.mod3;
        ADDR_MAIN_ONE: next_s.rd_data = s.main_set[23:16];
        ADDR_MAIN_TWO: next_s.rd_data = s.main_set[15:8];
        ADDR_MAIN_THREE: next_s.rd_data = s.main_set[7:0];
        ADDR_AUX_ONE: next_s.rd_data = s.aux_set[23:16];
        ADDR_AUX_TWO: next_s.rd_data = s.aux_set[15:8];
        ADDR_AUX_THREE: next_s.rd_data = s.aux_set[7:0];
        ADDR_PAGE_SEL: next_s.rd_data = s.page;
        ADDR_GAIN_STATUS: next_s.rd_data = 8'(s.rf_ready) << STAT_RF_READY;
        ADDR_PAGED_STATUS:
          if (s.page[1:0] == PAGE_SEGMENT)
            next_s.rd_data = {vco_segment, 1'b0,
              s.osc[OSC_MEASURE] ? vco_cv_level : 3'h0};
          else
            next_s.rd_data = 8'h00;
        ADDR_CMD_STATUS: next_s.rd_data = (8'(s.search_done) << STAT_SEARCH_DONE)
          | (8'(s.irq_cmd) << STAT_IRQ_CMD) | (8'(s.irq_ana) << STAT_IRQ_ANA);
        default: next_s.rd_data = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.rf_state <= RF_OFF;
    end
    else if (ce)
      s <= next_s;
  end

  // ramp duration timer
  hsc_cycle_timer #(.W(RAMP_W)) u_ramp_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .load(ramp_load),
    .load_value(ramp_len),
    .busy(),
    .done(ramp_done)
  );

  // crystal fast start timer
  hsc_cycle_timer #(.W(XOSC_W)) u_xosc_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .load(xosc_load),
    .load_value(XOSC_W'(XOSC_FAST_CYC)),
    .busy(),
    .done(xosc_done)
  );

  // segment search engine
  hsc_seg_search u_search (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .start(search_start),
    .cv_high(vco_cv_high),
    .busy(search_busy),
    .done(search_done),
    .segment(search_seg)
  );

  // synthesizer outputs
  assign test_out_fast_drive = s.misc1[MISC1_FAST_DRIVE];
  assign vco_segment = s.use_auto ? search_seg : s.osc[3:0];
  assign vco_cv_measure = s.osc[OSC_MEASURE];
  assign div_a = act_set[SET_A_LSB +: 10];
  assign div_b = act_set[SET_B_LSB +: 10];
  assign div_ratio = s.div_ratio;
  assign comparison_freq_select = s.main_set[SET_REF_LSB +: 3];
  assign ref_divide = (comparison_freq_select == REF_125K) ? REF_DIV_125K
    : (comparison_freq_select == REF_100K) ? REF_DIV_100K
    : (comparison_freq_select == REF_50K) ? REF_DIV_50K : REF_DIV_25K;
  assign pump_current_select = s.pump[2:0];
  assign loop_capacitor_select = s.pump[5:3];
  assign loop_resistor_select = s.pump[7:6];
  assign xosc_fast_mode = (s.misc2[MISC2_XOSC_LSB +: 2] == XOSC_FAST)
    || ((s.misc2[MISC2_XOSC_LSB +: 2] != XOSC_SAVE) && !s.xosc_done);

  // rf state outputs
  assign tx_enable = (s.rf_state != RF_OFF);
  assign rx_enable = tx_enable || s.dsc[DSC_RX_ONLY];
  assign agc_enable = s.dsc[DSC_AGC_ON];
  assign standby = s.dsc[DSC_STANDBY];
  assign rf_ramping = (s.rf_state == RF_UP) || (s.rf_state == RF_DOWN);
  assign rf_ready = s.rf_ready;
  assign irq = s.irq_cmd || s.irq_ana;
  assign reg_rd_data = s.rd_data;

  // protocol options, reserved sequencing code acts as none
  assign protocol_gen2 = (s.prot[2:0] == PROT_GEN2);
  assign protocol_fm0 = (s.prot[2:0] == PROT_FM0);
  assign auto_ack_en = (s.prot[PROT_SEQ_LSB +: 2] == SEQ_ACK)
    || (s.prot[PROT_SEQ_LSB +: 2] == SEQ_ACK_HANDLE);
  assign auto_handle_en = (s.prot[PROT_SEQ_LSB +: 2] == SEQ_ACK_HANDLE);
  assign rx_crc_check_en = !s.prot[PROT_NO_CRC];
  assign direct_mode = s.prot[PROT_DIRECT];

  // checks
  sequence up_end_s;
    ce && (s.rf_state == RF_UP) && rf_en && ramp_done;
  endsequence
  sequence down_end_s;
    ce && (s.rf_state == RF_DOWN) && ramp_done;
  endsequence

  fast_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && reg_wr_en && (reg_addr == ADDR_MISC_ONE)
    |=> test_out_fast_drive == $past(reg_wr_data[MISC1_FAST_DRIVE]))
    else $error("fast drive bit not taken from write");
  manual_seg_a: assert property (@(posedge core_clk) disable iff (rst)
    !s.use_auto |-> vco_segment == s.osc[3:0])
    else $error("manual segment differs from range field");
  search_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && search_done |=> irq && s.search_done)
    else $error("search end without irq and done flag");
  search_run_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_auto |=> search_busy && s.use_auto)
    else $error("auto range command did not start the search");
  manual_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_manual |=> !s.use_auto ##1 vco_segment == s.osc[3:0])
    else $error("manual command did not restore range field");
  page_read_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && reg_rd_en && (reg_addr == ADDR_PAGED_STATUS) && (s.page[1:0] == PAGE_SEGMENT)
    |=> reg_rd_data[7:4] == $past(vco_segment))
    else $error("paged status lacks segment");
  ratio_calc_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !reg_wr_en && !cmd_valid |=> div_ratio == 17'(div_b * 32) + 17'(div_a * 33))
    else $error("division ratio mismatch");
  hop_aux_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && (cmd_code == CMD_HOP_AUX) && !reg_wr_en
    |=> div_a == s.aux_set[9:0] && div_b == s.aux_set[19:10])
    else $error("aux hop did not select aux set");
  ramp_up_a: assert property (@(posedge core_clk) disable iff (rst)
    up_end_s |=> rf_ready && irq && (s.rf_state == RF_ENABLE))
    else $error("ramp up end without ready and irq");
  ramp_down_a: assert property (@(posedge core_clk) disable iff (rst)
    down_end_s |=> !tx_enable && s.irq_ana && !rf_ready)
    else $error("ramp down end without irq");
  ref_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    (comparison_freq_select == REF_125K) |-> ref_divide == REF_DIV_125K)
    else $error("reference divide wrong");

endmodule : hsc_synth_rf_ctrl

// >>> pkg/hsc_pkg.sv
// shared constants and types for the synthesizer and rf state control block
package hsc_pkg;

  // clock rate
  localparam int unsigned CORE_CLK_MHZ = 40;

  // register offsets
  localparam logic [7:0] ADDR_DEV_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PROTOCOL = 8'h01;
  localparam logic [7:0] ADDR_TX_OPTIONS = 8'h02;
  localparam logic [7:0] ADDR_MISC_ONE = 8'h0D;
  localparam logic [7:0] ADDR_MISC_TWO = 8'h0E;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h11;
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h12;
  localparam logic [7:0] ADDR_MOD_THREE = 8'h15;
  localparam logic [7:0] ADDR_MAIN_ONE = 8'h17;
  localparam logic [7:0] ADDR_MAIN_TWO = 8'h18;
  localparam logic [7:0] ADDR_MAIN_THREE = 8'h19;
  localparam logic [7:0] ADDR_AUX_ONE = 8'h1A;
  localparam logic [7:0] ADDR_AUX_TWO = 8'h1B;
  localparam logic [7:0] ADDR_AUX_THREE = 8'h1C;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h29;
  localparam logic [7:0] ADDR_GAIN_STATUS = 8'h2A;
  localparam logic [7:0] ADDR_PAGED_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_CMD_STATUS = 8'h2E;

  // value of every writable register after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // direct command codes
  localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
  localparam logic [7:0] CMD_HOP_AUX = 8'h85;
  localparam logic [7:0] CMD_AUTO_RANGE = 8'hA4;
  localparam logic [7:0] CMD_MANUAL_RANGE = 8'hA5;

  // field positions
  localparam int unsigned DSC_RF_ENABLE = 7;
  localparam int unsigned DSC_RX_ONLY = 6;
  localparam int unsigned DSC_AGC_ON = 2;
  localparam int unsigned DSC_STANDBY = 0;
  localparam int unsigned PROT_NO_CRC = 7;
  localparam int unsigned PROT_DIRECT = 6;
  localparam int unsigned PROT_SEQ_LSB = 4;
  localparam int unsigned MISC1_FAST_DRIVE = 0;
  localparam int unsigned MISC2_XOSC_LSB = 3;
  localparam int unsigned OSC_MEASURE = 7;
  localparam int unsigned MOD3_RAMP_LSB = 6;
  localparam int unsigned SET_A_LSB = 0;
  localparam int unsigned SET_B_LSB = 10;
  localparam int unsigned SET_REF_LSB = 20;
  localparam int unsigned STAT_RF_READY = 0;
  localparam int unsigned STAT_SEARCH_DONE = 0;
  localparam int unsigned STAT_IRQ_CMD = 6;
  localparam int unsigned STAT_IRQ_ANA = 7;

  // field encodings
  localparam logic [1:0] PAGE_SEGMENT = 2'h1;
  localparam logic [2:0] PROT_GEN2 = 3'h0;
  localparam logic [2:0] PROT_FM0 = 3'h1;
  localparam logic [1:0] SEQ_NONE = 2'h0;
  localparam logic [1:0] SEQ_ACK = 2'h1;
  localparam logic [1:0] SEQ_ACK_HANDLE = 2'h2;
  localparam logic [1:0] XOSC_AUTO = 2'h0;
  localparam logic [1:0] XOSC_FAST = 2'h1;
  localparam logic [1:0] XOSC_SAVE = 2'h2;
  localparam logic [2:0] REF_125K = 3'h0;
  localparam logic [2:0] REF_100K = 3'h1;
  localparam logic [2:0] REF_50K = 3'h2;

  // reference divide counts from the 20 MHz source
  localparam logic [9:0] REF_DIV_125K = 10'h0A0;
  localparam logic [9:0] REF_DIV_100K = 10'h0C8;
  localparam logic [9:0] REF_DIV_50K = 10'h190;
  localparam logic [9:0] REF_DIV_25K = 10'h320;

  // prescaler moduli
  localparam int unsigned PRESCALE_LOW = 32;
  localparam int unsigned PRESCALE_HIGH = 33;

  // ramp times
  localparam int unsigned RAMP_100_US = 100;
  localparam int unsigned RAMP_200_US = 200;
  localparam int unsigned RAMP_400_US = 400;
  localparam int unsigned RAMP_100_CYC = RAMP_100_US * CORE_CLK_MHZ;
  localparam int unsigned RAMP_200_CYC = RAMP_200_US * CORE_CLK_MHZ;
  localparam int unsigned RAMP_400_CYC = RAMP_400_US * CORE_CLK_MHZ;
  localparam int unsigned TARI_BASE_NS = 6250;
  localparam int unsigned TARI_BASE_CYC = TARI_BASE_NS * CORE_CLK_MHZ / 1000;
  localparam int unsigned TARI_RAMP_MULT = 16;
  localparam int unsigned RAMP_W = 16;

  // crystal fast start window
  localparam int unsigned XOSC_FAST_US = 1000;
  localparam int unsigned XOSC_FAST_CYC = XOSC_FAST_US * CORE_CLK_MHZ;
  localparam int unsigned XOSC_W = 20;

  // settle time per segment search step
  localparam int unsigned SEARCH_SETTLE_CYC = 16;

  // rf field states, gray along off, up, on, down
  typedef enum logic [1:0] {
    RF_OFF = 2'b00,
    RF_UP = 2'b01,
    RF_ENABLE = 2'b11,
    RF_DOWN = 2'b10
  } hsc_rf_e;

endpackage : hsc_pkg

// >>> test/hsc_synth_rf_ctrl_test.sv
// register level testbench of the synthesizer and rf state control
`timescale 1ns/10ps
module hsc_synth_rf_ctrl_test;
  import hsc_pkg::*;
  logic core_clk, rst, ce, reg_wr_en, reg_rd_en, cmd_valid, irq_ack, vco_cv_high, irq;
  logic test_out_fast_drive, vco_cv_measure, xosc_fast_mode, tx_enable, rx_enable, agc_enable;
  logic standby, rf_ramping, rf_ready, protocol_gen2, protocol_fm0, auto_ack_en, auto_handle_en;
  logic rx_crc_check_en, direct_mode;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, cmd_code;
  logic [3:0] vco_segment;
  logic [2:0] vco_cv_level, comparison_freq_select, pump_current_select, loop_capacitor_select;
  logic [1:0] loop_resistor_select;
  logic [9:0] div_a, div_b, ref_divide;
  logic [16:0] div_ratio;
  logic [7:0] pd [6] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h30, 8'hC0};
  logic [5:0] pe [6] = '{6'h22, 6'h12, 6'h2A, 6'h2E, 6'h22, 6'h21};
  int miscompares, checks_done, n, e;
  // design with shortened ramp and crystal windows
  hsc_synth_rf_ctrl #(.RAMP_100_CYC(20), .RAMP_200_CYC(40), .RAMP_400_CYC(80),
    .XOSC_FAST_CYC(50)) dut (.*);
  hsc_vco_model vco (.vco_segment(vco_segment), .vco_cv_high(vco_cv_high),
    .vco_cv_level(vco_cv_level));
  // clock source
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
      begin
        miscompares++;
        $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
  endtask : chk
  task final_report;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // one-cycle strobes launched at the falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk(reg_rd_data, exp);
  endtask : rd
  task cmd(input logic [7:0] c);
    @(negedge core_clk);
    cmd_code = c;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : cmd
  task ack;
    @(negedge core_clk);
    irq_ack = 1'b1;
    @(negedge core_clk);
    irq_ack = 1'b0;
  endtask : ack
  // bounded wait on rf_ready or irq, cycles left in n
  task wt(input bit sel, input int lim);
    n = 0;
    while (((sel ? rf_ready : irq) !== 1'b1) && n < lim)
      begin
        @(negedge core_clk);
        n++;
      end
    if (n >= lim)
      begin
        miscompares++;
        final_report;
      end
  endtask : wt
  // main sequence
  initial
  begin
    {rst, ce, reg_wr_en, reg_rd_en, cmd_valid, irq_ack} = 6'h30;
    {reg_addr, reg_wr_data, cmd_code} = '0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    chk({rx_crc_check_en, protocol_gen2, xosc_fast_mode, tx_enable}, 4'hE);
    chk(ref_divide, REF_DIV_125K);
    wr(ADDR_MISC_ONE, 8'h01);
    chk(test_out_fast_drive, 1'b1);
    wr(ADDR_OSC_CTRL, 8'h85);
    chk({vco_cv_measure, vco_segment}, 5'h15);
    wr(ADDR_PUMP_CTRL, 8'hEB);
    chk({loop_resistor_select, loop_capacitor_select, pump_current_select}, 8'hEB);
    wr(ADDR_MAIN_ONE, 8'h10);
    wr(ADDR_MAIN_TWO, 8'h40);
    wr(ADDR_MAIN_THREE, 8'h05);
    @(negedge core_clk);
    chk({div_b, div_a}, {10'h010, 10'h005});
    chk(div_ratio, 17'h002A5);
    chk({comparison_freq_select, ref_divide}, {3'h1, REF_DIV_100K});
    wr(ADDR_AUX_ONE, 8'h00);
    wr(ADDR_AUX_TWO, 8'h08);
    wr(ADDR_AUX_THREE, 8'h03);
    cmd(CMD_HOP_AUX);
    @(negedge core_clk);
    chk({div_b, div_a}, {10'h002, 10'h003});
    chk(div_ratio, 17'h000A3);
    cmd(CMD_HOP_MAIN);
    @(negedge core_clk);
    chk(div_ratio, 17'h002A5);
    wr(ADDR_MAIN_ONE, 8'h30);
    chk(ref_divide, REF_DIV_25K);
    // let the crystal fast start window run out
    repeat (30) @(negedge core_clk);
    chk(xosc_fast_mode, 1'b0);
    wr(ADDR_MISC_TWO, 8'h08);
    chk(xosc_fast_mode, 1'b1);
    wr(ADDR_MISC_TWO, 8'h10);
    chk(xosc_fast_mode, 1'b0);
    wr(ADDR_PAGE_SEL, 8'h01);
    cmd(CMD_AUTO_RANGE);
    wt(0, 400);
    rd(ADDR_CMD_STATUS, 8'h41);
    rd(ADDR_PAGED_STATUS, 8'hB5);
    chk(vco_segment, 4'hB);
    ack;
    chk(irq, 1'b0);
    wr(ADDR_OSC_CTRL, 8'h05);
    rd(ADDR_PAGED_STATUS, 8'hB0);
    cmd(CMD_MANUAL_RANGE);
    @(negedge core_clk);
    chk(vco_segment, 4'h5);
    for (int i = 0; i < 6; i++)
      begin
        wr(ADDR_PROTOCOL, pd[i]);
        chk({protocol_gen2, protocol_fm0, auto_ack_en, auto_handle_en, rx_crc_check_en,
          direct_mode}, pe[i]);
      end
    wr(ADDR_DEV_STATUS, 8'h45);
    chk({tx_enable, rx_enable, agc_enable, standby}, 4'h7);
    wr(ADDR_GAIN_STATUS, 8'hFF);
    rd(ADDR_GAIN_STATUS, 8'h00);
    rd(8'h3F, 8'h00);
    for (int k = 0; k < 4; k++)
      begin
        e = (k == 3) ? TARI_RAMP_MULT * TARI_BASE_CYC : 20 << k;
        wr(ADDR_MOD_THREE, 8'(k << 6));
        wr(ADDR_DEV_STATUS, 8'h80);
        @(negedge core_clk);
        chk({tx_enable, rf_ramping}, 2'h3);
        wt(1, e + 100);
        chk(n >= e - 2 && n <= e + 4, 1'b1);
        wt(0, 10);
        rd(ADDR_GAIN_STATUS, 8'h01);
        rd(ADDR_CMD_STATUS, 8'h80);
        ack;
        wr(ADDR_DEV_STATUS, 8'h00);
        wt(0, e + 100);
        chk(n >= e - 2 && n <= e + 4, 1'b1);
        chk({tx_enable, rf_ready}, 2'h0);
        ack;
      end
    // a low clock enable must freeze the registers
    ce = 1'b0;
    wr(ADDR_MISC_ONE, 8'h00);
    chk(test_out_fast_drive, 1'b1);
    ce = 1'b1;
    final_report;
  end
endmodule : hsc_synth_rf_ctrl_test

// >>> test/hsc_vco_model.sv
// analog comparator and control voltage stand-in for the oscillator
`timescale 1ns/10ps
module hsc_vco_model #(
  parameter logic [3:0] FIT_SEGMENT = 4'hB,
  parameter logic [2:0] CV_LEVEL = 3'h5
) (
  // oscillator side
  input wire logic [3:0] vco_segment,
  output logic vco_cv_high,
  output logic [2:0] vco_cv_level
);
  // voltage reads high while the trial segment is at or below the fitting one
  assign vco_cv_high = (vco_segment <= FIT_SEGMENT);
  assign vco_cv_level = CV_LEVEL;
endmodule : hsc_vco_model
